// File: rtl/tmon_pkg.sv
/*
  Shared constants and carrier types for the two-channel temperature
  conversion controller. Assumes a 200 MHz system clock.
*/
// Function
// - Free-running conversions only when standby input high and sw_standby_bit low.
// - One-shot command starts one conversion of both channels.
// - Conversion rate register sets the free-running interval.
// - Each conversion measures remote then local sensor, about 60 ms per sensor.
// - Results stored as 8-bit two's complement values.
// - Stored results compared with limits; outcome kept as status flags.
// - Out-of-limit result drives open-drain alert low.
// - Both channels measured; both results update together on completion.
// - Address select pins latched at start of every conversion.
// - Each address pin resolves to low, high or unconnected.
// - Each result is the average of 10 measurement cycles.
// - No clock-low timeout; transactions never aborted for long clock low.
// - Hardware standby low inhibits conversions and ignores one-shot.
// - One-shot still converts both channels in software standby.
// - Hardware standby mid-conversion aborts it; results stay unchanged.
// - Address pins also latched at power-up.
`default_nettype none
package tmon_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ           = 200;
  localparam int MEAS_TIME_MS      = 60;
  localparam int MEAS_CYCLES       = MEAS_TIME_MS * 1000 * CLK_MHZ;
  localparam int AVG_COUNT         = 10;
  localparam int RATE_BASE_MS      = 125;
  localparam int RATE_BASE_CYCLES  = RATE_BASE_MS * 1000 * CLK_MHZ;

  // ----------------------------------------
  // Reset values and maximum rate
  // ----------------------------------------
  localparam logic [7:0] RATE_RESET   = 8'h02;
  localparam logic [7:0] HI_LIM_RESET = 8'h7F;
  localparam logic [7:0] LO_LIM_RESET = 8'hC9;
  localparam logic [7:0] RATE_MAX     = 8'h07;

  // ----------------------------------------
  // Status bit positions
  // ----------------------------------------
  localparam int ST_BUSY  = 7;
  localparam int ST_LHIGH = 6;
  localparam int ST_LLOW  = 5;
  localparam int ST_RHIGH = 4;
  localparam int ST_RLOW  = 3;

  typedef enum logic [1:0] {
    PIN_LOW  = 2'b00,
    PIN_HIGH = 2'b01,
    PIN_OPEN = 2'b10
  } pin_level_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_REMOTE = 2'b01,
    ST_LOCAL  = 2'b10
  } conv_state_t;

  typedef struct packed {
    logic [7:0] local_high;
    logic [7:0] local_low;
    logic [7:0] remote_high;
    logic [7:0] remote_low;
  } limits_t;

  typedef struct packed {
    logic [7:0] local_temp;
    logic [7:0] remote_temp;
  } results_t;

endpackage : tmon_pkg
`default_nettype wire

// File: rtl/addr_pin_resolve.sv
/*
  Resolves one three-level address pin from a drive-high and a drive-low
  probe sample. Assumes the front end gives both samples per probe.
*/
`default_nettype none
module addr_pin_resolve (
  input  wire  logic                   clk,
  input  wire  logic                   rst_n,
  input  wire  logic                   sample,
  input  wire  logic                   probe_up,
  input  wire  logic                   probe_down,
  output var   tmon_pkg::pin_level_t   level
);
  // Pin follows both weak probes only when floating
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      level <= tmon_pkg::PIN_LOW;
    end else if (sample) begin
      if (probe_up && !probe_down) begin
        level <= tmon_pkg::PIN_OPEN;
      end else if (probe_up) begin
        level <= tmon_pkg::PIN_HIGH;
      end else begin
        level <= tmon_pkg::PIN_LOW;
      end
    end
  end
endmodule : addr_pin_resolve
`default_nettype wire

// File: rtl/avg_accum.sv
/*
  Averages AVG samples of a signed 8-bit converter value. Assumes
  one sample strobe per measurement cycle.
*/
`default_nettype none
module avg_accum #(
  parameter int AVG = tmon_pkg::AVG_COUNT
) (
  input  wire  logic              clk,
  input  wire  logic              rst_n,
  input  wire  logic              clear,
  input  wire  logic              strobe,
  input  wire  logic signed [7:0] sample,
  output logic signed [7:0]       mean
);
  logic signed [15:0] acc;

  always_ff @(posedge clk) begin
    if (!rst_n || clear) begin
      acc <= 16'sh0000;
    end else if (strobe) begin
      acc <= acc + 16'(sample);
    end
  end

  // Truncating divide keeps the result in range; costs up to 1 LSB
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mean <= 8'sh00;
    end else begin
      mean <= 8'(acc / 16'(AVG));
    end
  end
endmodule : avg_accum
`default_nettype wire

// File: rtl/temp_conv_ctrl.sv
/*
  Conversion sequencer for a two-channel temperature monitor: timing,
  averaging, result storage, limit compare and alert. Assumes the serial
  slave decodes commands into the plain control ports here, and that the
  analog converter presents one sample per ADC_STROBE.
*/
`default_nettype none
module temp_conv_ctrl #(
  parameter int MEAS_CYCLES      = tmon_pkg::MEAS_CYCLES,
  parameter int RATE_BASE_CYCLES = tmon_pkg::RATE_BASE_CYCLES,
  parameter int AVG              = tmon_pkg::AVG_COUNT
) (
  input  wire  logic                  SYS_CLK,
  input  wire  logic                  NRST,
  input  wire  logic                  HW_STANDBY_INPUT_N,
  input  wire  logic                  SW_STANDBY_BIT,
  input  wire  logic                  ALERT_MASK,
  input  wire  logic                  ONE_SHOT,
  input  wire  logic [7:0]            CONV_RATE,
  input  wire  tmon_pkg::limits_t     LIMITS,
  input  wire  logic                  ADC_STROBE,
  input  wire  logic [7:0]            ADC_SAMPLE,
  input  wire  logic                  ADDR_SELECT_PIN_A_UP,
  input  wire  logic                  ADDR_SELECT_PIN_A_DOWN,
  input  wire  logic                  ADDR_SELECT_PIN_B_UP,
  input  wire  logic                  ADDR_SELECT_PIN_B_DOWN,
  output logic                        ADDR_PROBE,
  output tmon_pkg::pin_level_t        ADDR_A,
  output tmon_pkg::pin_level_t        ADDR_B,
  output logic                        SENSE_REMOTE,
  output logic                        SENSE_LOCAL,
  output tmon_pkg::results_t          RESULTS,
  output logic [7:0]                  STATUS,
  output logic                        ALERT_OUT,
  output logic                        ALERT_OE
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  tmon_pkg::conv_state_t state;
  logic [31:0]           meas_cnt;
  logic [31:0]           period_cnt;
  logic [3:0]            samples;
  logic                  por_probe;
  logic                  start;
  logic                  chan_done;
  logic                  acc_clear;
  logic signed [7:0]     mean;
  logic                  store_local;
  logic [7:0]            remote_hold;
  logic                  fault;
  logic                  free_run;
  tmon_pkg::pin_level_t  lvl_a;
  tmon_pkg::pin_level_t  lvl_b;
  logic                  mean_ready;
  logic                  remote_settled;
  logic                  local_settled;
  logic                  take_sample;

  function automatic logic [31:0] rate_period(input logic [7:0] rate);
    logic [7:0] r;
    r = (rate > tmon_pkg::RATE_MAX) ? tmon_pkg::RATE_MAX : rate;
    // Period halves per step from 16 base units at rate 0
    rate_period = 32'(RATE_BASE_CYCLES) << (4'd7 - r[3:0]) >> 3;
  endfunction : rate_period

  assign free_run  = HW_STANDBY_INPUT_N && !SW_STANDBY_BIT;
  // One-shot honoured in software standby, never under hardware standby
  assign start     = (state == tmon_pkg::ST_IDLE) && HW_STANDBY_INPUT_N
                     && (ONE_SHOT || (free_run && period_cnt == 32'h0000_0000));
  assign chan_done = (state != tmon_pkg::ST_IDLE)
                     && (meas_cnt == 32'(MEAS_CYCLES - 1)) && mean_ready;
  assign acc_clear = start || chan_done;
  // Converter lags the sense switch by a cycle; a sample from the old sensor is dropped
  assign take_sample = ADC_STROBE && (samples != 4'(AVG))
                       && ((state == tmon_pkg::ST_REMOTE && remote_settled)
                       || (state == tmon_pkg::ST_LOCAL && local_settled));

  // ----------------------------------------
  // Rate timer
  // ----------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      period_cnt <= 32'h0000_0000;
    end else if (start) begin
      period_cnt <= rate_period(CONV_RATE) - 32'h0000_0001;
    end else if (period_cnt != 32'h0000_0000) begin
      period_cnt <= period_cnt - 32'h0000_0001;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      state <= tmon_pkg::ST_IDLE;
    end else if (!HW_STANDBY_INPUT_N) begin
      state <= tmon_pkg::ST_IDLE;
    end else begin
      case (state)
        tmon_pkg::ST_IDLE: begin
          if (start) begin
            state <= tmon_pkg::ST_REMOTE;
          end
        end
        tmon_pkg::ST_REMOTE: begin
          if (chan_done) begin
            state <= tmon_pkg::ST_LOCAL;
          end
        end
        tmon_pkg::ST_LOCAL: begin
          if (chan_done) begin
            state <= tmon_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= tmon_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Channel window counter; the slot may outlast the needed samples
  always_ff @(posedge SYS_CLK) begin
    if (!NRST || acc_clear || state == tmon_pkg::ST_IDLE) begin
      meas_cnt   <= 32'h0000_0000;
      samples    <= 4'h0;
      mean_ready <= 1'b0;
    end else begin
      if (meas_cnt != 32'(MEAS_CYCLES - 1)) begin
        meas_cnt <= meas_cnt + 32'h0000_0001;
      end
      if (take_sample) begin
        samples <= samples + 4'h1;
      end
      // Averager output lags the last sample by one cycle
      mean_ready <= (samples == 4'(AVG));
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      SENSE_REMOTE <= 1'b0;
      SENSE_LOCAL  <= 1'b0;
    end else begin
      SENSE_REMOTE <= HW_STANDBY_INPUT_N && (start || (state == tmon_pkg::ST_REMOTE && !chan_done));
      SENSE_LOCAL  <= HW_STANDBY_INPUT_N && ((state == tmon_pkg::ST_LOCAL && !chan_done)
                      || (state == tmon_pkg::ST_REMOTE && chan_done));
    end
  end

  // One cycle of sense history marks samples that belong to this channel
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      remote_settled <= 1'b0;
      local_settled  <= 1'b0;
    end else begin
      remote_settled <= SENSE_REMOTE;
      local_settled  <= SENSE_LOCAL;
    end
  end

  avg_accum #(
    .AVG (AVG)
  ) u_avg (
    .clk    (SYS_CLK),
    .rst_n  (NRST),
    .clear  (acc_clear),
    .strobe (take_sample),
    .sample (ADC_SAMPLE),
    .mean   (mean)
  );

  // ----------------------------------------
  // Result storage
  // ----------------------------------------
  // Mean settles one cycle after the last sample; it is taken at chan_done
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      remote_hold <= 8'h00;
      store_local <= 1'b0;
      RESULTS     <= '0;
    end else begin
      store_local <= 1'b0;
      if (chan_done && state == tmon_pkg::ST_REMOTE && HW_STANDBY_INPUT_N) begin
        remote_hold <= mean;
      end
      if (chan_done && state == tmon_pkg::ST_LOCAL && HW_STANDBY_INPUT_N) begin
        // Both channels land together, never one at a time
        RESULTS.local_temp  <= mean;
        RESULTS.remote_temp <= remote_hold;
        store_local         <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Limit compare and status
  // ----------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      STATUS <= 8'h00;
    end else begin
      STATUS[tmon_pkg::ST_BUSY] <= (state != tmon_pkg::ST_IDLE);
      if (store_local) begin
        STATUS[tmon_pkg::ST_LHIGH] <= $signed(RESULTS.local_temp)  > $signed(LIMITS.local_high);
        STATUS[tmon_pkg::ST_LLOW]  <= $signed(RESULTS.local_temp)  < $signed(LIMITS.local_low);
        STATUS[tmon_pkg::ST_RHIGH] <= $signed(RESULTS.remote_temp) > $signed(LIMITS.remote_high);
        STATUS[tmon_pkg::ST_RLOW]  <= $signed(RESULTS.remote_temp) < $signed(LIMITS.remote_low);
      end
    end
  end

  assign fault = |STATUS[tmon_pkg::ST_LHIGH:tmon_pkg::ST_RLOW];

  // Open drain: only ever pulls low, never drives high
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      ALERT_OUT <= 1'b0;
      ALERT_OE  <= 1'b0;
    end else begin
      ALERT_OUT <= 1'b0;
      ALERT_OE  <= fault && !ALERT_MASK;
    end
  end

  // ----------------------------------------
  // Address pin latch
  // ----------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      por_probe  <= 1'b1;
      ADDR_PROBE <= 1'b0;
    end else begin
      por_probe  <= 1'b0;
      ADDR_PROBE <= por_probe || start;
    end
  end

  addr_pin_resolve u_pin_a (
    .clk        (SYS_CLK),
    .rst_n      (NRST),
    .sample     (ADDR_PROBE),
    .probe_up   (ADDR_SELECT_PIN_A_UP),
    .probe_down (ADDR_SELECT_PIN_A_DOWN),
    .level      (lvl_a)
  );

  addr_pin_resolve u_pin_b (
    .clk        (SYS_CLK),
    .rst_n      (NRST),
    .sample     (ADDR_PROBE),
    .probe_up   (ADDR_SELECT_PIN_B_UP),
    .probe_down (ADDR_SELECT_PIN_B_DOWN),
    .level      (lvl_b)
  );

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      ADDR_A <= tmon_pkg::PIN_LOW;
      ADDR_B <= tmon_pkg::PIN_LOW;
    end else begin
      ADDR_A <= lvl_a;
      ADDR_B <= lvl_b;
    end
  end

  // No bus timeout lives here: nothing watches the serial clock at all

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);

  standby_blocks_start_a: assert property (!HW_STANDBY_INPUT_N |-> ##1 state == tmon_pkg::ST_IDLE)
    else $error("conversion active under hardware standby");
  free_run_gate_a: assert property (start && !ONE_SHOT |-> HW_STANDBY_INPUT_N && !SW_STANDBY_BIT)
    else $error("periodic start outside free-running mode");
  oneshot_sw_a: assert property (state == tmon_pkg::ST_IDLE && ONE_SHOT && HW_STANDBY_INPUT_N
                                 |=> state == tmon_pkg::ST_REMOTE)
    else $error("one-shot did not start a conversion");
  no_overlap_a: assert property (state != tmon_pkg::ST_IDLE |-> !start)
    else $error("overlapping conversion start");
  probe_on_start_a: assert property (start |=> ADDR_PROBE)
    else $error("address pins not sampled at start");
  both_update_a: assert property (!store_local |-> $stable(RESULTS))
    else $error("results changed outside completion");
  abort_keeps_a: assert property ($fell(HW_STANDBY_INPUT_N) |=> ##1 $stable(RESULTS))
    else $error("results updated after abort");
  compare_flag_a: assert property (store_local && $signed(RESULTS.local_temp) > $signed(LIMITS.local_high)
                                   |=> STATUS[tmon_pkg::ST_LHIGH])
    else $error("high limit flag missing");
  alert_drive_a: assert property (fault && !ALERT_MASK |=> ALERT_OE && !ALERT_OUT)
    else $error("alert not pulled low");
  rate_load_a: assert property (start |=> period_cnt == rate_period($past(CONV_RATE)) - 32'h0000_0001)
    else $error("conversion interval not loaded");
  sense_exclusive_a: assert property (!(SENSE_REMOTE && SENSE_LOCAL))
    else $error("both current sources routed at once");
  standby_sense_a: assert property (!HW_STANDBY_INPUT_N |=> !SENSE_REMOTE && !SENSE_LOCAL)
    else $error("current source on under hardware standby");
  low_flag_a: assert property (store_local && $signed(RESULTS.remote_temp) < $signed(LIMITS.remote_low)
                               |=> STATUS[tmon_pkg::ST_RLOW])
    else $error("remote low limit flag missing");
  alert_release_a: assert property (!fault |=> !ALERT_OE)
    else $error("alert held without a limit fault");

  cov_oneshot_c: cover property (state == tmon_pkg::ST_IDLE && ONE_SHOT && SW_STANDBY_BIT ##1 state != tmon_pkg::ST_IDLE);
  cov_complete_c: cover property (store_local);
  cov_abort_c: cover property (state != tmon_pkg::ST_IDLE ##1 !HW_STANDBY_INPUT_N);
  cov_alert_c: cover property (ALERT_OE);
endmodule : temp_conv_ctrl
`default_nettype wire

// File: verification/adc_front_model.sv
/*
  Stand-in for the analog front end: strobes one sample per measurement
  cycle while a sensor is selected and answers the address pin probes.
  Assumes the controller selects at most one sensor at a time.
*/
`default_nettype none
module adc_front_model (
  input  wire logic                 clk,
  input  wire logic                 sense_remote,
  input  wire logic                 sense_local,
  input  wire logic                 slow,
  input  wire logic [7:0]           remote_temp,
  input  wire logic [7:0]           local_temp,
  input  wire tmon_pkg::pin_level_t pin_a,
  input  wire tmon_pkg::pin_level_t pin_b,
  output var  logic                 strobe,
  output var  logic [7:0]           sample,
  output var  logic                 a_up,
  output var  logic                 a_down,
  output var  logic                 b_up,
  output var  logic                 b_down
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       busy;
  logic [3:0] div = 4'h0;
  initial strobe = 1'b0;
  initial sample = 8'h00;
  assign busy = sense_remote || sense_local;
  // Slow mode makes the sample count, not the time, end a channel
  always @(posedge clk) begin
    if (!busy || div == (slow ? 4'h7 : 4'h2)) begin
      div <= 4'h0;
    end else begin
      div <= div + 4'h1;
    end
    strobe <= busy && div == 4'h0;
    // Toggle between strobes so a stale byte never looks valid
    sample <= (busy && div == 4'h0) ? (sense_remote ? remote_temp : local_temp) : ~sample;
  end
  assign a_up   = pin_a != tmon_pkg::PIN_LOW;
  assign a_down = pin_a == tmon_pkg::PIN_HIGH;
  assign b_up   = pin_b != tmon_pkg::PIN_LOW;
  assign b_down = pin_b == tmon_pkg::PIN_HIGH;
endmodule : adc_front_model
`default_nettype wire

// File: verification/dual_channel_temp_conversion_control_tb.sv
/*
  Self-checking bench for the conversion sequencer: standby, one-shot,
  abort, free-running period, limits, alert and address latching.
  Assumes the front-end model drives the converter and pin probe inputs.
*/
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module dual_channel_temp_conversion_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int MEAS = 50;
  logic                 clk = 1'b0, nrst = 1'b0, hw_n = 1'b0, sw_sb = 1'b0;
  logic                 mask = 1'b0, one_shot = 1'b0, slow = 1'b0;
  logic [7:0]           rate = 8'h00, rt = 8'h00, lt = 8'h00;
  tmon_pkg::limits_t    lims = '0;
  tmon_pkg::pin_level_t pa = tmon_pkg::PIN_HIGH, pb = tmon_pkg::PIN_OPEN, addr_a, addr_b;
  logic                 strobe, a_up, a_down, b_up, b_down, probe, s_rem, s_loc, alert, alert_oe;
  logic [7:0]           sample, status;
  tmon_pkg::results_t   res, prev;
  int                   num_errors = 0, cmp_count = 0, seed = 60362, cyc = 0, overlap = 0;
  int                   rem_cyc, loc_cyc, rem_stb, np, n;
  int                   probe_q[$];
  always #2.5 clk = ~clk;
  temp_conv_ctrl #(.MEAS_CYCLES(MEAS), .RATE_BASE_CYCLES(20), .AVG(10)) i_dut (
    .SYS_CLK(clk), .NRST(nrst), .HW_STANDBY_INPUT_N(hw_n), .SW_STANDBY_BIT(sw_sb), .ALERT_MASK(mask),
    .ONE_SHOT(one_shot), .CONV_RATE(rate), .LIMITS(lims), .ADC_STROBE(strobe), .ADC_SAMPLE(sample),
    .ADDR_SELECT_PIN_A_UP(a_up), .ADDR_SELECT_PIN_A_DOWN(a_down), .ADDR_SELECT_PIN_B_UP(b_up),
    .ADDR_SELECT_PIN_B_DOWN(b_down), .ADDR_PROBE(probe), .ADDR_A(addr_a), .ADDR_B(addr_b),
    .SENSE_REMOTE(s_rem), .SENSE_LOCAL(s_loc), .RESULTS(res), .STATUS(status), .ALERT_OUT(alert),
    .ALERT_OE(alert_oe));
  adc_front_model i_front (.clk(clk), .sense_remote(s_rem), .sense_local(s_loc), .slow(slow),
    .remote_temp(rt), .local_temp(lt), .pin_a(pa), .pin_b(pb), .strobe(strobe), .sample(sample),
    .a_up(a_up), .a_down(a_down), .b_up(b_up), .b_down(b_down));
  // ----------------------------------------
  // Monitor, sampled on the falling edge where outputs are settled
  // ----------------------------------------
  always @(negedge clk) begin
    cyc++;
    if (probe === 1'b1) begin
      probe_q.push_back(cyc);
      rem_cyc = 0;
      loc_cyc = 0;
      rem_stb = 0;
    end
    if (s_rem === 1'b1) rem_cyc++;
    if (s_loc === 1'b1) loc_cyc++;
    if (s_rem === 1'b1 && strobe === 1'b1) rem_stb++;
    if (s_rem === 1'b1 && s_loc === 1'b1) overlap++;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask : tick
  task automatic shot;
    @(posedge clk);
    one_shot <= 1'b1;
    @(posedge clk);
    one_shot <= 1'b0;
  endtask : shot
  task automatic wait_idle;
    int k;
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (status[7] !== 1'b0 && k < 3000);
    `CHK("idle_wait", 1'b0, status[7])
    tick(2);
    #1;
  endtask : wait_idle
  task automatic print_verdict;
    $display("Comparisons %0d, errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  // ----------------------------------------
  // One-shot conversion with a repeat request and pin change mid-run
  // ----------------------------------------
  task automatic convert(input int i);
    logic [7:0] st;
    prev = res;
    @(posedge clk);
    rt <= 8'($random(seed)) | 8'h01;
    lt <= 8'($random(seed)) | 8'h01;
    lims <= tmon_pkg::limits_t'($random(seed) & 32'hFEFE_FEFE);
    mask <= i[0];
    slow <= i > 3;
    pa <= tmon_pkg::pin_level_t'(i % 3);
    pb <= tmon_pkg::pin_level_t'((i + 1) % 3);
    np = probe_q.size();
    shot;
    tick(40);
    #1;
    `CHK("held_results", prev, res)
    @(posedge clk);
    pa <= tmon_pkg::pin_level_t'((i + 2) % 3);
    shot;
    wait_idle;
    st = {1'b0, $signed(lt) > $signed(lims.local_high), $signed(lt) < $signed(lims.local_low),
          $signed(rt) > $signed(lims.remote_high), $signed(rt) < $signed(lims.remote_low), 3'b000};
    `CHK("probes", np + 1, probe_q.size())
    `CHK("addr_a", tmon_pkg::pin_level_t'(i % 3), addr_a)
    `CHK("addr_b", tmon_pkg::pin_level_t'((i + 1) % 3), addr_b)
    `CHK("remote", rt, res.remote_temp)
    `CHK("local", lt, res.local_temp)
    `CHK("status", st, status)
    `CHK("alert_oe", |st & ~mask, alert_oe)
    `CHK("alert_level", 1'b0, alert)
    `CHK("sense_time", 1'b1, rem_cyc >= MEAS && loc_cyc >= MEAS)
    `CHK("sense_order", 0, overlap)
    `CHK("avg_count", 1'b1, rem_stb >= 10)
  endtask : convert
  initial begin
    tick(4);
    nrst <= 1'b1;
    tick(4);
    #1;
    `CHK("powerup_addr_a", tmon_pkg::PIN_HIGH, addr_a)
    `CHK("powerup_addr_b", tmon_pkg::PIN_OPEN, addr_b)
    `CHK("reset_status", 8'h00, status)
    shot;
    tick(20);
    #1;
    `CHK("hw_standby_shot", 1, probe_q.size())
    @(posedge clk);
    hw_n <= 1'b1;
    sw_sb <= 1'b1;
    tick(30);
    #1;
    `CHK("sw_standby_idle", 1, probe_q.size())
    for (int i = 0; i < 6; i++) convert(i);
    // ----------------------------------------
    // Hardware standby in mid-conversion
    // ----------------------------------------
    prev = res;
    @(posedge clk);
    rt <= 8'h11;
    shot;
    tick(60);
    hw_n <= 1'b0;
    tick(3);
    #1;
    `CHK("abort_busy", 1'b0, status[7])
    np = probe_q.size();
    shot;
    tick(100);
    #1;
    `CHK("abort_results", prev, res)
    `CHK("standby_shot", np, probe_q.size())
    // ----------------------------------------
    // Free-running period, measured start to start
    // ----------------------------------------
    @(posedge clk);
    hw_n <= 1'b1;
    sw_sb <= 1'b0;
    for (int r = 0; r < 2; r++) begin
      rate <= 8'(r);
      np = probe_q.size();
      n = 0;
      while (probe_q.size() < np + 3 && n < 2000) begin
        @(posedge clk);
        n++;
      end
      `CHK("period_starts", np + 3, probe_q.size())
      `CHK("period", 320 >> r, probe_q[$] - probe_q[$-1])
    end
    sw_sb <= 1'b1;
    tick(200);
    np = probe_q.size();
    tick(400);
    #1;
    `CHK("sw_standby_stop", np, probe_q.size())
    print_verdict;
  end
  initial begin
    tick(20000);
    num_errors++;
    print_verdict;
  end
endmodule : dual_channel_temp_conversion_control_tb
`default_nettype wire
